/* ecct_defs.svh */
// Register map, field positions, reset values and counts of the capture/compare timer.
`ifndef ECCT_DEFS_SVH
`define ECCT_DEFS_SVH
`define ECCT_A_FUNC     8'h80
`define ECCT_A_FORCE    8'h84
`define ECCT_A_MMASK    8'h88
`define ECCT_A_MDATA    8'h8c
`define ECCT_A_CNT      8'h90
`define ECCT_A_CTRL     8'h94
`define ECCT_A_NOVW     8'h98
`define ECCT_A_ACT      8'h9c
`define ECCT_A_DIR      8'ha0
`define ECCT_A_PORT     8'ha4
`define ECCT_A_MOD      8'ha8
`define ECCT_A_FLAT     8'hac
`define ECCT_R_ACCH     4'hb
`define ECCT_R_CAP      3'b110
`define ECCT_R_HOLD     4'he
`define ECCT_R_ACC      4'hf
`define ECCT_C_TEN      0
`define ECCT_C_SWAI     1
`define ECCT_C_QUEUE_LATCH_SELECT     2
`define ECCT_C_SAT      3
`define ECCT_C_PAIR0    4
`define ECCT_C_MODPER   6
`define ECCT_C_MODEN    7
`define ECCT_C_MODZ     8
`define ECCT_RST8       8'h00
`define ECCT_RST16      16'h0000
`define ECCT_SAT8       8'hff
`define ECCT_SAT16      16'hffff
`define ECCT_DIV64_LAST 6'h3f
`define ECCT_RESP_OK    2'b00
`define ECCT_RESP_ERR   2'b10
`endif

/* ecct_pkg.sv */
// Types shared by the capture/compare timer.
package ecct_pkg;
    typedef logic [7:0] ecct_byte_t;
    typedef logic [15:0] ecct_word_t;
    typedef enum logic [1:0]
    {
        ECCT_ACT_NONE   = 2'h0,
        ECCT_ACT_TOGGLE = 2'h1,
        ECCT_ACT_CLEAR  = 2'h2,
        ECCT_ACT_SET    = 2'h3
    } ecct_act_t;
endpackage

/* ecct_timer.sv */
// Eight-channel capture/compare timer with queued captures and pulse accumulators, AXI4-Lite slave.
//
// Operation
// - Capture register takes the main count on each valid input edge.
// - Queue mode: old capture moves to holding, then the new count is captured.
// - No-overwrite set: capture and holding written only when empty.
// - Queue mode: reading a holding register copies its accumulator to accumulator holding.
// - Four 8-bit accumulators count input edges, each with an 8-bit holding register.
// - Saturate bit stops each accumulator at its maximum value.
// - Each accumulator pair can count as one 16-bit accumulator.
// - Latch mode: modulus zero, zero write or force latch copy and clear accumulators.
// - Queue mode: holding-register read transfers and clears the accumulator together.
// - Modulus down-counter is a time base and periodic or single-shot latch trigger.
// - An enabled output compare forces its pin to output regardless of direction.
// - Port writes on peripheral-owned pins are latched and driven once released.
// - Function select bit: 0 capture, 1 compare; resets to zero; always accessible.
// - Force compare performs the compare action without a flag; reads return zero.
// - Master mask bit makes a compare channel's pin an output, direction unchanged.
// - Channel 7 compare copies master data bits onto masked port bits.
// - Master mask bit blocks that bit's own output action.
// - Channel 7 wins over a simultaneous compare on a masked bit.
// - Main counter: 16-bit up-counter, reset zero, writable only in special mode.
// - Counter write is not synchronised with the prescaler.
// - Timer enable clear stops the main timer and counter.
// - Divide-by-64 tick comes from the prescaler, absent when the timer is idle.
// - Stop-in-wait halts timer, accumulators and modulus counter in wait mode.
// - Capture register is empty once read or moved to holding.
// - Holding register is empty once read.
`timescale 1ns/100ps
`include "ecct_defs.svh"
module ecct_timer
(
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]         awaddr,
    input  wire logic [2:0]         awprot,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    // AXI4-Lite write response
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    // AXI4-Lite read
    input  wire logic [7:0]         araddr,
    input  wire logic [2:0]         arprot,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // Timer port pins
    input  wire ecct_pkg::ecct_byte_t timer_in,
    output ecct_pkg::ecct_byte_t    timer_out,
    output ecct_pkg::ecct_byte_t    timer_oe_n,
    // Chip mode
    input  wire logic               wait_mode,
    input  wire logic               special_mode_n
);
    import ecct_pkg::*;

    localparam int NCH  = 8;
    localparam int NBUF = 4;

    logic             awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]       bresp_ff, rresp_ff;
    logic [31:0]      rdata_ff;
    logic             aw_got_ff, w_got_ff;
    logic [7:0]       waddr_ff;
    logic [31:0]      wdata_ff;
    logic [3:0]       wstrb_ff;
    logic             nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
    ecct_byte_t       in_s1_ff, in_s2_ff, in_s3_ff, edge_v;
    ecct_byte_t       func_ff, mmask_ff, mdata_ff, dir_ff, port_ff, novw_ff, ctrl_ff;
    ecct_byte_t       out_ff, oe_n_ff, oc_lvl_ff, owned, oc_go, force_now;
    ecct_word_t       act_ff, free_running_counter_ff, mod_ff, modld_ff;
    logic             modz_ff;
    logic [5:0]       presc_ff;
    ecct_word_t       cap_ff [NCH];
    logic             cap_full_ff [NCH];
    ecct_byte_t       hold_ff_lo [NBUF];
    ecct_byte_t       hold_ff_hi [NBUF];
    logic             hold_full_ff [NBUF];
    ecct_byte_t       pa_ff [NBUF];
    ecct_byte_t       pah_ff [NBUF];
    logic [NBUF-1:0]  xfer, rd_hold;
    logic [NCH-1:0]   rd_cap;
    logic             ar_hs, aw_hs, w_hs, wr_do, wb0, wb1, active, div64_tick;
    logic             mod_zero_evt, mod_wr_zero, force_latch, lat_evt, queue_latch_select;
    logic [31:0]      rd_data;
    logic             rd_ok;

    function automatic ecct_word_t merge16(input ecct_word_t old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && ((a >= `ECCT_A_FUNC && a <= `ECCT_A_FLAT) || a[7:4] >= `ECCT_R_ACCH);
    endfunction

    function automatic ecct_byte_t acc8(input ecct_byte_t cur, input logic clr, input logic inc, input logic sat);
        ecct_byte_t base;
        base = clr ? `ECCT_RST8 : cur;
        acc8 = (sat && base == `ECCT_SAT8) ? base : base + {7'h00, inc};
    endfunction

    assign awready    = awready_ff;
    assign wready     = wready_ff;
    assign bvalid     = bvalid_ff;
    assign bresp      = bresp_ff;
    assign arready    = arready_ff;
    assign rvalid     = rvalid_ff;
    assign rresp      = rresp_ff;
    assign rdata      = rdata_ff;
    assign timer_out  = out_ff;
    assign timer_oe_n = oe_n_ff;

    // Bus handshakes: one write and one read outstanding at most.
    assign aw_hs = awvalid & awready_ff;
    assign w_hs  = wvalid & wready_ff;
    assign ar_hs = arvalid & arready_ff;
    assign wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;
    assign wb0   = wr_do & wstrb_ff[0] & mapped(waddr_ff);
    assign wb1   = wr_do & wstrb_ff[1] & mapped(waddr_ff);

    always_comb
    begin
        nxt_aw_got = aw_hs | (aw_got_ff & ~wr_do);
        nxt_w_got  = w_hs | (w_got_ff & ~wr_do);
        nxt_bvalid = wr_do | (bvalid_ff & ~bready);
        nxt_rvalid = ar_hs | (rvalid_ff & ~rready);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `ECCT_RESP_OK;
            waddr_ff   <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end
        else
        begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            if (aw_hs)
                waddr_ff <= awaddr;
            if (w_hs)
            begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (wr_do)
                bresp_ff <= mapped(waddr_ff) ? `ECCT_RESP_OK : `ECCT_RESP_ERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= `ECCT_RESP_OK;
            rdata_ff   <= 32'h0000_0000;
        end
        else
        begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_hs)
            begin
                rdata_ff <= rd_data;
                rresp_ff <= rd_ok ? `ECCT_RESP_OK : `ECCT_RESP_ERR;
            end
        end
    end

    // Read mux; the force strobe register always reads zero.
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_ok   = mapped(araddr);
        if (!rd_ok)
            rd_data = 32'h0000_0000;
        else if (araddr[7:5] == `ECCT_R_CAP)
            rd_data[15:0] = cap_ff[araddr[4:2]];
        else if (araddr[7:4] == `ECCT_R_HOLD)
            rd_data[15:0] = {hold_ff_hi[araddr[3:2]], hold_ff_lo[araddr[3:2]]};
        else if (araddr[7:4] == `ECCT_R_ACC)
            rd_data[7:0] = pa_ff[araddr[3:2]];
        else if (araddr[7:4] == `ECCT_R_ACCH)
            rd_data[7:0] = pah_ff[araddr[3:2]];
        else
        begin
            case (araddr)
                `ECCT_A_FUNC:  rd_data[7:0] = func_ff;
                `ECCT_A_MMASK: rd_data[7:0] = mmask_ff;
                `ECCT_A_MDATA: rd_data[7:0] = mdata_ff;
                `ECCT_A_CNT:   rd_data[15:0] = free_running_counter_ff;
                `ECCT_A_CTRL:  rd_data[8:0] = {modz_ff, ctrl_ff};
                `ECCT_A_NOVW:  rd_data[7:0] = novw_ff;
                `ECCT_A_ACT:   rd_data[15:0] = act_ff;
                `ECCT_A_DIR:   rd_data[7:0] = dir_ff;
                `ECCT_A_PORT:  rd_data[7:0] = (dir_ff & port_ff) | (~dir_ff & in_s2_ff);
                `ECCT_A_MOD:   rd_data[15:0] = mod_ff;
                default:       rd_data = 32'h0000_0000;
            endcase
        end
    end

    // Input pins pass two flip-flops; the third stage only serves edge detection.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_s1_ff <= `ECCT_RST8;
            in_s2_ff <= `ECCT_RST8;
            in_s3_ff <= `ECCT_RST8;
        end
        else
        begin
            in_s1_ff <= timer_in;
            in_s2_ff <= in_s1_ff;
            in_s3_ff <= in_s2_ff;
        end
    end

    // Wait mode with stop-in-wait freezes every counter; there is no wake source here.
    assign active     = ctrl_ff[`ECCT_C_TEN] & ~(wait_mode & ctrl_ff[`ECCT_C_SWAI]);
    assign div64_tick = active & (presc_ff == `ECCT_DIV64_LAST);
    assign edge_v     = (in_s2_ff & ~in_s3_ff) & {NCH{active}};
    assign queue_latch_select       = ctrl_ff[`ECCT_C_QUEUE_LATCH_SELECT];
    assign force_now  = (wb0 && waddr_ff == `ECCT_A_FORCE) ? wdata_ff[7:0] : `ECCT_RST8;
    assign force_latch = wb0 && waddr_ff == `ECCT_A_FLAT;
    assign mod_wr_zero = wb0 && waddr_ff == `ECCT_A_MOD && merge16(mod_ff, wdata_ff, wstrb_ff) == `ECCT_RST16;
    assign mod_zero_evt = ctrl_ff[`ECCT_C_MODEN] & div64_tick & (mod_ff == 16'h0001);
    assign lat_evt    = queue_latch_select & (mod_zero_evt | mod_wr_zero | force_latch);

    // Software registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            func_ff  <= `ECCT_RST8;
            mmask_ff <= `ECCT_RST8;
            mdata_ff <= `ECCT_RST8;
            dir_ff   <= `ECCT_RST8;
            port_ff  <= `ECCT_RST8;
            novw_ff  <= `ECCT_RST8;
            act_ff   <= `ECCT_RST16;
        end
        else if (wb0 || wb1)
        begin
            case (waddr_ff)
                `ECCT_A_FUNC:  if (wb0) func_ff <= wdata_ff[7:0];
                `ECCT_A_MMASK: if (wb0) mmask_ff <= wdata_ff[7:0];
                `ECCT_A_MDATA: if (wb0) mdata_ff <= wdata_ff[7:0];
                `ECCT_A_DIR:   if (wb0) dir_ff <= wdata_ff[7:0];
                `ECCT_A_PORT:  if (wb0) port_ff <= wdata_ff[7:0];
                `ECCT_A_NOVW:  if (wb0) novw_ff <= wdata_ff[7:0];
                `ECCT_A_ACT:   act_ff <= merge16(act_ff, wdata_ff, wstrb_ff);
                default:       act_ff <= act_ff;
            endcase
        end
    end

    // Control bits and the modulus down-counter; single-shot clears its own enable at zero.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_ff  <= `ECCT_RST8;
            modz_ff  <= 1'b0;
            mod_ff   <= `ECCT_RST16;
            modld_ff <= `ECCT_RST16;
        end
        else
        begin
            if (wb0 && waddr_ff == `ECCT_A_CTRL)
                ctrl_ff <= wdata_ff[7:0];
            if (mod_zero_evt && !ctrl_ff[`ECCT_C_MODPER])
                ctrl_ff[`ECCT_C_MODEN] <= 1'b0;
            if (mod_zero_evt)
                modz_ff <= 1'b1;
            else if (wb1 && waddr_ff == `ECCT_A_CTRL && wdata_ff[`ECCT_C_MODZ])
                modz_ff <= 1'b0;
            if (wr_do && mapped(waddr_ff) && waddr_ff == `ECCT_A_MOD)
            begin
                mod_ff   <= merge16(mod_ff, wdata_ff, wstrb_ff);
                modld_ff <= merge16(mod_ff, wdata_ff, wstrb_ff);
            end
            else if (mod_zero_evt)
                mod_ff <= ctrl_ff[`ECCT_C_MODPER] ? modld_ff : `ECCT_RST16;
            else if (ctrl_ff[`ECCT_C_MODEN] && div64_tick && mod_ff != `ECCT_RST16)
                mod_ff <= mod_ff - 16'h0001;
        end
    end

    // Prescaler and main counter. A counter write leaves the prescaler phase alone.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            presc_ff <= 6'h00;
            free_running_counter_ff  <= `ECCT_RST16;
        end
        else
        begin
            if (active)
                presc_ff <= presc_ff + 6'h01;
            if (wr_do && mapped(waddr_ff) && waddr_ff == `ECCT_A_CNT && !special_mode_n)
                free_running_counter_ff <= merge16(free_running_counter_ff, wdata_ff, wstrb_ff);
            else if (active)
                free_running_counter_ff <= free_running_counter_ff + 16'h0001;
        end
    end

    // Capture channels; buffered ones carry a holding register and the queue logic.
    genvar n;
    generate
        for (n = 0; n < NCH; n++)
        begin : g_ch
            logic cap_wr, do_cap, do_move, ev;
            assign ev     = edge_v[n] & ~func_ff[n];
            assign cap_wr = wr_do && mapped(waddr_ff) && waddr_ff[7:5] == `ECCT_R_CAP && waddr_ff[4:2] == 3'(n);
            assign rd_cap[n] = ar_hs && rd_ok && araddr[7:5] == `ECCT_R_CAP && araddr[4:2] == 3'(n);
            assign oc_go[n] = (active && func_ff[n] && free_running_counter_ff == cap_ff[n]) || (force_now[n] && func_ff[n]);
            if (n < NBUF)
            begin : g_buf
                assign rd_hold[n] = ar_hs && rd_ok && araddr[7:4] == `ECCT_R_HOLD && araddr[3:2] == 2'(n);
                always_comb
                begin
                    if (!queue_latch_select)
                    begin
                        do_cap  = ev & (~novw_ff[n] | ~cap_full_ff[n] | ~hold_full_ff[n]);
                        do_move = do_cap & (~novw_ff[n] | cap_full_ff[n]);
                    end
                    else
                    begin
                        do_cap  = ev & (~novw_ff[n] | ~cap_full_ff[n]);
                        do_move = lat_evt & (~novw_ff[n] | ~hold_full_ff[n]);
                    end
                end
                always_ff @(posedge aclk)
                begin
                    if (!aresetn)
                    begin
                        hold_ff_lo[n]   <= `ECCT_RST8;
                        hold_ff_hi[n]   <= `ECCT_RST8;
                        hold_full_ff[n] <= 1'b0;
                    end
                    else if (do_move)
                    begin
                        {hold_ff_hi[n], hold_ff_lo[n]} <= cap_ff[n];
                        hold_full_ff[n] <= cap_full_ff[n];
                    end
                    else if (rd_hold[n])
                        hold_full_ff[n] <= 1'b0;
                end
            end
            else
            begin : g_plain
                assign do_cap  = ev & (~novw_ff[n] | ~cap_full_ff[n]);
                assign do_move = 1'b0;
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    cap_ff[n]      <= `ECCT_RST16;
                    cap_full_ff[n] <= 1'b0;
                end
                else
                begin
                    if (do_cap)
                        cap_ff[n] <= free_running_counter_ff;
                    else if (cap_wr)
                        cap_ff[n] <= merge16(cap_ff[n], wdata_ff, wstrb_ff);
                    if (do_cap)
                        cap_full_ff[n] <= 1'b1;
                    else if (do_move || rd_cap[n])
                        cap_full_ff[n] <= 1'b0;
                end
            end
        end
    endgenerate

    // Accumulator transfer: latch events in latch mode, holding-register reads in queue mode.
    assign xfer = queue_latch_select ? {NBUF{lat_evt}} : rd_hold;

    genvar k;
    generate
        for (k = 0; k < NBUF / 2; k++)
        begin : g_pair
            logic       paired, sat, xp;
            ecct_word_t base16;
            assign paired = ctrl_ff[`ECCT_C_PAIR0 + k];
            assign sat    = ctrl_ff[`ECCT_C_SAT];
            assign xp     = xfer[2*k] | xfer[2*k+1];
            assign base16 = xp ? `ECCT_RST16 : {pa_ff[2*k+1], pa_ff[2*k]};
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    pa_ff[2*k]    <= `ECCT_RST8;
                    pa_ff[2*k+1]  <= `ECCT_RST8;
                    pah_ff[2*k]   <= `ECCT_RST8;
                    pah_ff[2*k+1] <= `ECCT_RST8;
                end
                else if (paired)
                begin
                    if (!(sat && base16 == `ECCT_SAT16))
                        {pa_ff[2*k+1], pa_ff[2*k]} <= base16 + {15'h0000, edge_v[2*k]};
                    else
                        {pa_ff[2*k+1], pa_ff[2*k]} <= base16;
                    if (xp)
                    begin
                        pah_ff[2*k]   <= pa_ff[2*k];
                        pah_ff[2*k+1] <= pa_ff[2*k+1];
                    end
                end
                else
                begin
                    pa_ff[2*k]   <= acc8(pa_ff[2*k], xfer[2*k], edge_v[2*k], sat);
                    pa_ff[2*k+1] <= acc8(pa_ff[2*k+1], xfer[2*k+1], edge_v[2*k+1], sat);
                    if (xfer[2*k])
                        pah_ff[2*k] <= pa_ff[2*k];
                    if (xfer[2*k+1])
                        pah_ff[2*k+1] <= pa_ff[2*k+1];
                end
            end
        end
    endgenerate

    // Compare outputs and pin ownership.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            oc_lvl_ff <= `ECCT_RST8;
            out_ff    <= `ECCT_RST8;
            oe_n_ff   <= `ECCT_SAT8;
        end
        else
        begin
            for (int b = 0; b < NCH; b++)
            begin
                if (mmask_ff[b])
                begin
                    if (oc_go[7])
                        oc_lvl_ff[b] <= mdata_ff[b];
                end
                else if (oc_go[b])
                begin
                    case (ecct_act_t'(act_ff[2*b +: 2]))
                        ECCT_ACT_TOGGLE: oc_lvl_ff[b] <= ~oc_lvl_ff[b];
                        ECCT_ACT_CLEAR:  oc_lvl_ff[b] <= 1'b0;
                        ECCT_ACT_SET:    oc_lvl_ff[b] <= 1'b1;
                        default:         oc_lvl_ff[b] <= oc_lvl_ff[b];
                    endcase
                end
                out_ff[b]  <= owned[b] ? oc_lvl_ff[b] : port_ff[b];
                oe_n_ff[b] <= ~(owned[b] | dir_ff[b]);
            end
        end
    end

    always_comb
    begin
        for (int b = 0; b < NCH; b++)
            owned[b] = func_ff[b] & (mmask_ff[b] | (act_ff[2*b +: 2] != 2'h0));
    end

endmodule // ecct_timer

/* ecct_timer_props.sv */
// Bus and pin checker bound to the capture/compare timer.
`timescale 1ns/100ps
module ecct_timer_props
(
    // Clock, reset, bus handshakes and pins
    input wire logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic        arvalid, arready, rvalid, rready,
    input wire logic [1:0]  bresp, rresp,
    input wire logic [31:0] rdata,
    input wire logic [7:0]  timer_oe_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_take |-> ##2 bvalid) else $error("write answer late");
    AST_RD_ANSWER: assert property (s_rd_take |=> rvalid) else $error("read answer late");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r dropped");
    AST_AR_BLOCK: assert property (rvalid |-> !arready) else $error("read taken early");
    AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
    AST_RESP_CODE: assert property (rvalid |-> rresp inside {2'b00, 2'b10}) else $error("bad rresp");
    AST_OE_RESET: assert property ($rose(aresetn) |-> timer_oe_n == 8'hff) else $error("pin driven");
endmodule // ecct_timer_props
bind ecct_timer ecct_timer_props i_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .bready, .arvalid, .arready, .rvalid, .rready, .bresp, .rresp, .rdata, .timer_oe_n);

/* ecct_pins.sv */
// External timer port pins: a source drives each pin only where the timer does not.
`timescale 1ns/100ps
module ecct_pins
(
    // Pin sides
    input wire logic [7:0] timer_out,
    input wire logic [7:0] timer_oe_n,
    input wire logic [7:0] ext_level,
    output logic [7:0]     timer_in
);
    // A driven pin reads back its own level, so capture logic sees the real wire.
    assign timer_in = (timer_oe_n & ext_level) | (~timer_oe_n & timer_out);
endmodule // ecct_pins

/* ecct_timer_tb_top.sv */
// Self-checking bench for the capture/compare timer.
`timescale 1ns/100ps
module ecct_timer_tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, wait_mode = 0, special_mode_n = 1;
    logic [7:0] awaddr = 0, araddr = 0, timer_out, timer_oe_n, timer_in, ext_level = 0;
    logic [31:0] wdata = 0, rdata, seed = 32'h2ae343a3;
    logic [1:0] bresp, rresp;
    logic [34:0] exp_q[$];
    int errors = 0, tests_run = 0;
    ecct_timer i_dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .timer_in, .timer_out, .timer_oe_n, .wait_mode, .special_mode_n);
    ecct_pins i_pins (.timer_out, .timer_oe_n, .ext_level, .timer_in);
    initial forever #20 aclk = ~aclk;
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        tests_run++;
        if (seen !== want)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit got;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1;
        wvalid  <= 1;
        bready  <= 1;
        got = 0;
        for (int n = 0; n < 50 && !got; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid)
            begin
                bready <= 0;
                got = 1;
            end
        end
        if (!got)
        begin
            errors++;
            summarize();
        end
    endtask
    // Bit 34 of a note marks a value that depends on free-running time and is not compared.
    task automatic rd(input logic [7:0] a, input logic [34:0] e);
        bit got;
        @(posedge aclk);
        exp_q.push_back(e);
        araddr  <= a;
        arvalid <= 1;
        rready  <= 1;
        got = 0;
        for (int n = 0; n < 50 && !got; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid)
            begin
                rready <= 0;
                got = 1;
            end
        end
        if (!got)
        begin
            errors++;
            summarize();
        end
    endtask
    // Every write in this bench goes to a mapped register, so each answer must be OKAY.
    always @(posedge aclk)
    begin
        if (bvalid && bready) chk(bresp, 0);
        if (rvalid && rready && exp_q.size() > 0)
        begin
            automatic logic [34:0] e = exp_q.pop_front();
            if (!e[34]) chk({rresp, rdata}, e[33:0]);
        end
    end
    task automatic pulses(input int ch, input int cnt);
        repeat (cnt)
        begin
            @(posedge aclk) ext_level[ch] <= 1;
            repeat (3) @(posedge aclk);
            ext_level[ch] <= 0;
            repeat (3) @(posedge aclk);
        end
    endtask
    task automatic tst(input string s);
        $display("test %s done", s);
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        seed = lfsr(seed);
        rd(8'h80, 0);
        wr(8'h80, seed[7:0]);
        rd(8'h80, seed[7:0]);
        wr(8'h84, 0);
        rd(8'h84, 0);
        rd(8'h7c, {3'b010, 32'h0});
        tst("registers");
        wr(8'h90, 32'h1234);
        rd(8'h90, 0);
        special_mode_n <= 0;
        wr(8'h90, 32'h1234);
        rd(8'h90, 32'h1234);
        special_mode_n <= 1;
        tst("counter");
        wr(8'h80, 0);
        wr(8'h94, 1);
        pulses(0, 3);
        rd(8'hf0, 3);
        rd(8'he0, 35'h4_0000_0000);
        rd(8'hb0, 3);
        rd(8'hf0, 0);
        tst("queue");
        wr(8'h94, 5);
        pulses(0, 2);
        wr(8'hac, 1);
        rd(8'hb0, 2);
        rd(8'hf0, 0);
        tst("latch");
        wr(8'h94, 9);
        pulses(0, 260);
        rd(8'hf0, 8'hff);
        tst("saturate");
        wr(8'h94, 3);
        wait_mode <= 1;
        pulses(1, 2);
        wait_mode <= 0;
        rd(8'hf4, 0);
        tst("wait");
        // The holding read clears the whole pair; 257 edges must carry into the high byte.
        wr(8'h94, 8'h11);
        rd(8'he0, 35'h4_0000_0000);
        pulses(0, 257);
        rd(8'hf4, 1);
        rd(8'hf0, 1);
        tst("pair");
        wr(8'h80, 8'h83);
        wr(8'h9c, 3);
        wr(8'h84, 1);
        repeat (3) @(posedge aclk);
        chk({timer_oe_n[0], timer_out[0]}, 2'b01);
        wr(8'h88, 2);
        wr(8'h8c, 2);
        wr(8'h84, 8'h80);
        repeat (3) @(posedge aclk);
        chk({timer_oe_n[1], timer_out[1]}, 2'b01);
        rd(8'ha0, 0);
        wr(8'ha0, 1);
        wr(8'ha4, 0);
        repeat (3) @(posedge aclk);
        chk({timer_oe_n[0], timer_out[0]}, 2'b01);
        wr(8'h80, 8'h82);
        repeat (3) @(posedge aclk);
        chk({timer_oe_n[0], timer_out[0]}, 2'b00);
        tst("compare");
        // Single shot from one: the zero flag rises and the enable clears itself within one tick period.
        wr(8'ha8, 1);
        wr(8'h94, 8'h85);
        repeat (70) @(posedge aclk);
        rd(8'h94, 9'h105);
        tst("modulus");
        summarize();
    end
endmodule // ecct_timer_tb_top
